// ---- hdl/sp3c_map.svh ----
// Register offsets, reset values and field positions of the port-3 control block.
// Assumes an 8-bit register port with byte addresses in the special function space.
`ifndef SP3C_MAP_SVH
`define SP3C_MAP_SVH

`define SP3C_ADDR_MODE_A_THR  8'hAC
`define SP3C_ADDR_MODE_B_SLEW 8'hAD
`define SP3C_ADDR_PIN_DATA    8'hB0
`define SP3C_ADDR_PAGE_CTRL   8'hB8

`define SP3C_RST_MODE_A       8'h01
`define SP3C_RST_MODE_B       8'h00
`define SP3C_RST_THRESHOLD    8'h00
`define SP3C_RST_SLEW         8'h00
`define SP3C_RST_PIN_DATA     8'h01
`define SP3C_RST_PAGE         1'h0

`define SP3C_BIT_PIN          0
`define SP3C_BIT_PAGE         0
`define SP3C_BIT_OSC_SEL      1

`endif

// ---- hdl/sp3c_pkg.sv ----
// Types shared by the port-3 control block.
// Assumes the map header is compiled alongside.
`default_nettype none

package sp3c_pkg;
	typedef enum logic [1:0] {
		SP3C_QUASI     = 2'b00,
		SP3C_PUSH_PULL = 2'b01,
		SP3C_INPUT     = 2'b10,
		SP3C_OPEN_DRN  = 2'b11
	} sp3c_mode_t;
endpackage : sp3c_pkg

`default_nettype wire

// ---- hdl/sp3c_cfg_if.sv ----
// Carrier between the register file and the pin driver.
// Assumes a single system clock domain.
`default_nettype none

interface sp3c_cfg_if;
	import sp3c_pkg::*;
	sp3c_mode_t mode;
	logic       latch;
	logic       gpio_en;
	logic       pin_level;
	modport regs (output mode, output latch, output gpio_en, input pin_level);
	modport pad  (input mode, input latch, input gpio_en, output pin_level);
endinterface : sp3c_cfg_if

`default_nettype wire

// ---- hdl/sp3c_pad_drv.sv ----
// Pin driver: turns mode and latch into drive signals and samples the pin.
// Assumes the pad cell resolves the wire from output and enable.
`default_nettype none

module sp3c_pad_drv
	import sp3c_pkg::*;
(
	input  wire logic i_ref_clk,    // System clock
	input  wire logic i_rst,        // Synchronous reset
	input  wire logic i_pin,        // Pin level
	output logic      o_pin,        // Pin drive value
	output logic      o_pin_oe,     // Pin drive enable
	output logic      o_weak_pu,    // Weak pull-up on
	sp3c_cfg_if.pad   cfg           // Mode and latch
);
	logic pin_q;

	wire drive_one  = (cfg.mode == SP3C_PUSH_PULL) && cfg.latch;
	wire drive_zero = (cfg.mode != SP3C_INPUT) && !cfg.latch;
	wire drive_en   = cfg.gpio_en && (drive_one || drive_zero);

	assign o_pin     = drive_one;
	assign o_pin_oe  = drive_en;
	assign o_weak_pu = cfg.gpio_en && (cfg.mode == SP3C_QUASI) && cfg.latch;

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			pin_q <= 1'b0;
		end else begin
			pin_q <= i_pin;
		end
	end

	assign cfg.pin_level = pin_q;
endmodule : sp3c_pad_drv

`default_nettype wire

// ---- hdl/sp3c_top.sv ----
// Port-3 single-pin control: paged mode, threshold, slew and data registers.
// Assumes a one-cycle register port; read data stands the cycle after the strobe.
//
// Implementation choice: the strobed register port.
`default_nettype none
`include "sp3c_map.svh"

// Summary of operation
// - Pin mode comes from both mode bits taken together.
// - Mode code 00 to 11, mode one as high bit: quasi, push-pull, input, open-drain.
// - Mode one resets to 01h, mode two to zero; pin starts input-only.
// - Address ACh is mode one on page 0, threshold on page 1.
// - Address ADh is mode two on page 0, slew on page 1; both reset zero.
// - Threshold bit 0 selects TTL input, 1 Schmitt input.
// - Slew bit 0 selects normal slew, 1 high-speed slew.
// - Data register resets to 01h.
// - Data bits 7:1 read zero and ignore writes.
// - Bit 0 is general I/O only with internal oscillator as clock.
// - Otherwise the pin becomes the external oscillator input.
// - In oscillator mode, data bit 0 writes ignored and reads zero.
module sp3c_top
	import sp3c_pkg::*;
(
	input  wire logic       i_ref_clk,     // System clock, 250 MHz
	input  wire logic       i_rst,         // Synchronous reset, active high
	input  wire logic [7:0] i_addr,        // Register address
	input  wire logic [7:0] i_wdata,       // Write data
	input  wire logic       i_wr,          // Write strobe
	input  wire logic       i_rd,          // Read strobe
	output logic      [7:0] o_rdata,       // Read data, cycle after strobe
	input  wire logic       i_pin,         // Pin level in
	output logic            o_pin,         // Pin drive value
	output logic            o_pin_oe,      // Pin drive enable
	output logic            o_weak_pu,     // Quasi mode weak pull-up
	output logic            o_schmitt,     // Schmitt receiver select
	output logic            o_fast_slew,   // High-speed slew select
	output logic            o_osc_in_en,   // Pin routed to oscillator input
	output logic            o_page         // Current register page
);
	logic [7:0] mode_select_one_reg;
	logic [7:0] mode_select_two_reg;
	logic [7:0] input_threshold_reg;
	logic [7:0] slew_control_reg;
	logic [7:0] port_data_reg;
	logic       page_sel;
	logic       osc_internal;
	logic [7:0] rdata;

	sp3c_cfg_if cfg ();

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
		hit = (a == ref_a);
	endfunction : hit

	wire sel_a    = hit(i_addr, `SP3C_ADDR_MODE_A_THR);
	wire sel_b    = hit(i_addr, `SP3C_ADDR_MODE_B_SLEW);
	wire sel_data = hit(i_addr, `SP3C_ADDR_PIN_DATA);
	wire sel_page = hit(i_addr, `SP3C_ADDR_PAGE_CTRL);

	wire wr_mode_one = i_wr && sel_a && !page_sel;
	wire wr_thresh   = i_wr && sel_a && page_sel;
	wire wr_mode_two = i_wr && sel_b && !page_sel;
	wire wr_slew     = i_wr && sel_b && page_sel;
	wire wr_page     = i_wr && sel_page;
	// writes take effect only in I/O mode
	wire wr_data     = i_wr && sel_data && osc_internal;

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			mode_select_one_reg <= `SP3C_RST_MODE_A;
			mode_select_two_reg <= `SP3C_RST_MODE_B;
		end else begin
			if (wr_mode_one) mode_select_one_reg <= {7'h00, i_wdata[`SP3C_BIT_PIN]};
			if (wr_mode_two) mode_select_two_reg <= {7'h00, i_wdata[`SP3C_BIT_PIN]};
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			input_threshold_reg <= `SP3C_RST_THRESHOLD;
			slew_control_reg    <= `SP3C_RST_SLEW;
		end else begin
			if (wr_thresh) input_threshold_reg <= {7'h00, i_wdata[`SP3C_BIT_PIN]};
			if (wr_slew)   slew_control_reg    <= {7'h00, i_wdata[`SP3C_BIT_PIN]};
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			port_data_reg <= `SP3C_RST_PIN_DATA;
		end else if (wr_data) begin
			port_data_reg <= {7'h00, i_wdata[`SP3C_BIT_PIN]};
		end
	end

	// Page and clock-source control share one register
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			page_sel     <= `SP3C_RST_PAGE;
			osc_internal <= 1'b1;
		end else if (wr_page) begin
			page_sel     <= i_wdata[`SP3C_BIT_PAGE];
			osc_internal <= !i_wdata[`SP3C_BIT_OSC_SEL];
		end
	end

	assign cfg.mode    = sp3c_mode_t'({mode_select_one_reg[`SP3C_BIT_PIN],
	                                   mode_select_two_reg[`SP3C_BIT_PIN]});
	assign cfg.latch   = port_data_reg[`SP3C_BIT_PIN];
	// pin drives only in I/O mode
	assign cfg.gpio_en = osc_internal;

	sp3c_pad_drv u_pad (
		.i_ref_clk (i_ref_clk),
		.i_rst     (i_rst),
		.i_pin     (i_pin),
		.o_pin     (o_pin),
		.o_pin_oe  (o_pin_oe),
		.o_weak_pu (o_weak_pu),
		.cfg       (cfg.pad)
	);

	wire       data_bit  = osc_internal && cfg.pin_level;
	wire [7:0] page_word = {6'h00, !osc_internal, page_sel};
	wire [7:0] a_word    = page_sel ? input_threshold_reg : mode_select_one_reg;
	wire [7:0] b_word    = page_sel ? slew_control_reg : mode_select_two_reg;
	wire [7:0] rd_mux    = sel_a ? a_word :
	                       sel_b ? b_word :
	                       sel_data ? {7'h00, data_bit} :
	                       sel_page ? page_word : 8'h00;

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			rdata <= 8'h00;
		end else begin
			rdata <= i_rd ? rd_mux : 8'h00;
		end
	end

	assign o_rdata     = rdata;
	assign o_schmitt   = input_threshold_reg[`SP3C_BIT_PIN];
	assign o_fast_slew = slew_control_reg[`SP3C_BIT_PIN];
	assign o_osc_in_en = !osc_internal;
	assign o_page      = page_sel;

	// Assertions
	property p_mode_in_after_reset;
		@(posedge i_ref_clk) $fell(i_rst) |-> (cfg.mode == SP3C_INPUT) && !o_pin_oe;
	endproperty
	a_mode_in_after_reset: assert property (p_mode_in_after_reset)
		else $error("pin not input-only after reset");

	property p_mode_pair;
		@(posedge i_ref_clk) disable iff (i_rst)
		(mode_select_one_reg[0] && mode_select_two_reg[0] && osc_internal)
		|-> !o_pin && !o_weak_pu && (o_pin_oe == !port_data_reg[`SP3C_BIT_PIN]);
	endproperty
	a_mode_pair: assert property (p_mode_pair)
		else $error("mode pair decode wrong");

	property p_push_pull_drive;
		@(posedge i_ref_clk) disable iff (i_rst)
		(cfg.mode == SP3C_PUSH_PULL && osc_internal) |-> o_pin_oe && (o_pin == cfg.latch);
	endproperty
	a_push_pull_drive: assert property (p_push_pull_drive)
		else $error("push-pull not driving latch");

	property p_page1_write;
		@(posedge i_ref_clk) disable iff (i_rst)
		(i_wr && sel_a && page_sel) |=> $stable(mode_select_one_reg)
		&& input_threshold_reg[0] == $past(i_wdata[0]);
	endproperty
	a_page1_write: assert property (p_page1_write)
		else $error("page 1 write misrouted");

	property p_page0_write_b;
		@(posedge i_ref_clk) disable iff (i_rst)
		(i_wr && sel_b && !page_sel) |=> $stable(slew_control_reg)
		&& mode_select_two_reg[0] == $past(i_wdata[0]);
	endproperty
	a_page0_write_b: assert property (p_page0_write_b)
		else $error("page 0 write misrouted");

	property p_reserved_zero;
		@(posedge i_ref_clk) disable iff (i_rst)
		(i_rd && sel_data) |=> o_rdata[7:1] == 7'h00;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved data bits not zero");

	property p_osc_write_ignored;
		@(posedge i_ref_clk) disable iff (i_rst)
		(i_wr && sel_data && !osc_internal) |=> $stable(port_data_reg);
	endproperty
	a_osc_write_ignored: assert property (p_osc_write_ignored)
		else $error("data write taken in oscillator mode");

	property p_osc_read_zero;
		@(posedge i_ref_clk) disable iff (i_rst)
		(i_rd && sel_data && !osc_internal) |=> o_rdata == 8'h00 ##0 !o_pin_oe;
	endproperty
	a_osc_read_zero: assert property (p_osc_read_zero)
		else $error("oscillator mode read not zero");

	property p_gpio_read_pin;
		@(posedge i_ref_clk) disable iff (i_rst)
		(i_rd && sel_data && osc_internal) ##1 1'b1 |-> o_rdata[0] == $past(i_pin, 2);
	endproperty
	a_gpio_read_pin: assert property (p_gpio_read_pin)
		else $error("read does not return pin level");

	property p_reset_mode;
		@(posedge i_ref_clk)
		i_rst |=> mode_select_one_reg == `SP3C_RST_MODE_A && mode_select_two_reg == `SP3C_RST_MODE_B;
	endproperty
	a_reset_mode: assert property (p_reset_mode)
		else $error("mode registers not at reset value");

	property p_reset_paged;
		@(posedge i_ref_clk)
		i_rst |=> input_threshold_reg == `SP3C_RST_THRESHOLD && slew_control_reg == `SP3C_RST_SLEW;
	endproperty
	a_reset_paged: assert property (p_reset_paged)
		else $error("threshold or slew register not at reset value");

	property p_reset_data;
		@(posedge i_ref_clk)
		i_rst |=> port_data_reg == `SP3C_RST_PIN_DATA;
	endproperty
	a_reset_data: assert property (p_reset_data)
		else $error("data register not at reset value");

	property p_reset_page;
		@(posedge i_ref_clk)
		i_rst |=> page_sel == `SP3C_RST_PAGE && osc_internal;
	endproperty
	a_reset_page: assert property (p_reset_page)
		else $error("page or clock source not at reset value");

	property p_page0_write_a;
		@(posedge i_ref_clk) disable iff (i_rst)
		(i_wr && sel_a && !page_sel) |=> $stable(input_threshold_reg)
		&& mode_select_one_reg[0] == $past(i_wdata[0]);
	endproperty
	a_page0_write_a: assert property (p_page0_write_a)
		else $error("page 0 write at mode one misrouted");

	property p_page1_write_b;
		@(posedge i_ref_clk) disable iff (i_rst)
		(i_wr && sel_b && page_sel) |=> $stable(mode_select_two_reg)
		&& slew_control_reg[0] == $past(i_wdata[0]);
	endproperty
	a_page1_write_b: assert property (p_page1_write_b)
		else $error("page 1 write at slew misrouted");

	property p_page_write;
		@(posedge i_ref_clk) disable iff (i_rst)
		wr_page |=> page_sel == $past(i_wdata[`SP3C_BIT_PAGE]);
	endproperty
	a_page_write: assert property (p_page_write)
		else $error("page bit not taken from write");

	property p_schmitt_write;
		@(posedge i_ref_clk) disable iff (i_rst)
		wr_thresh |=> o_schmitt == $past(i_wdata[0]);
	endproperty
	a_schmitt_write: assert property (p_schmitt_write)
		else $error("receiver select does not follow threshold bit");

	property p_slew_write;
		@(posedge i_ref_clk) disable iff (i_rst)
		wr_slew |=> o_fast_slew == $past(i_wdata[0]);
	endproperty
	a_slew_write: assert property (p_slew_write)
		else $error("slew select does not follow slew bit");

	property p_reserved_regs;
		@(posedge i_ref_clk) disable iff (i_rst)
		port_data_reg[7:1] == 7'h00 && mode_select_one_reg[7:1] == 7'h00;
	endproperty
	a_reserved_regs: assert property (p_reserved_regs)
		else $error("reserved register bits set");

	property p_osc_no_drive;
		@(posedge i_ref_clk) disable iff (i_rst)
		!osc_internal |-> !o_pin_oe && !o_weak_pu && o_osc_in_en;
	endproperty
	a_osc_no_drive: assert property (p_osc_no_drive)
		else $error("pin driven while oscillator input");

	property p_osc_sel;
		@(posedge i_ref_clk) disable iff (i_rst)
		wr_page |=> osc_internal == !$past(i_wdata[`SP3C_BIT_OSC_SEL]);
	endproperty
	a_osc_sel: assert property (p_osc_sel)
		else $error("clock source select not taken from write");

	property p_gpio_write;
		@(posedge i_ref_clk) disable iff (i_rst)
		(i_wr && sel_data && osc_internal) |=> port_data_reg[0] == $past(i_wdata[0]);
	endproperty
	a_gpio_write: assert property (p_gpio_write)
		else $error("data write not taken in I/O mode");

	property p_gpio_latch_drive;
		@(posedge i_ref_clk) disable iff (i_rst)
		(osc_internal && cfg.mode != SP3C_INPUT && !cfg.latch) |-> o_pin_oe && !o_pin;
	endproperty
	a_gpio_latch_drive: assert property (p_gpio_latch_drive)
		else $error("latch zero does not drive pin low");

	property p_quasi_drive;
		@(posedge i_ref_clk) disable iff (i_rst)
		(cfg.mode == SP3C_QUASI && osc_internal)
		|-> !o_pin && (o_pin_oe == !cfg.latch) && (o_weak_pu == cfg.latch);
	endproperty
	a_quasi_drive: assert property (p_quasi_drive)
		else $error("quasi mode drive wrong");

	property p_input_hiz;
		@(posedge i_ref_clk) disable iff (i_rst)
		(cfg.mode == SP3C_INPUT) |-> !o_pin_oe && !o_weak_pu && !o_pin;
	endproperty
	a_input_hiz: assert property (p_input_hiz)
		else $error("input-only mode drives the pin");

	c_page1: cover property (@(posedge i_ref_clk) disable iff (i_rst) wr_thresh);
	c_osc_mode: cover property (@(posedge i_ref_clk) disable iff (i_rst) $rose(o_osc_in_en));
	c_open_drain: cover property (@(posedge i_ref_clk) disable iff (i_rst)
		cfg.mode == SP3C_OPEN_DRN && o_pin_oe);
	c_data_read: cover property (@(posedge i_ref_clk) disable iff (i_rst) i_rd && sel_data);
	c_quasi_pullup: cover property (@(posedge i_ref_clk) disable iff (i_rst) o_weak_pu);
endmodule : sp3c_top

`default_nettype wire

// ---- bench/sp3c_board.sv ----
// Board model on the port-3 pin: device drive, weak pull-up or a board source.
// Assumes one system clock; a pin nobody holds toggles every cycle.
`default_nettype none

module sp3c_board (
	input  wire logic i_ref_clk,  // System clock
	input  wire logic i_drv,      // Device drive value
	input  wire logic i_oe,       // Device drive enable
	input  wire logic i_pu,       // Device weak pull-up
	input  wire logic i_ext_en,   // Board source enable
	input  wire logic i_ext_val,  // Board source value
	output logic      o_level     // Resolved pin level
);
	timeunit 1ns;
	timeprecision 100ps;
	logic float_q = 1'b0;
	// Floating pin must not look like a stable level
	always_ff @(posedge i_ref_clk) begin
		float_q <= ~float_q;
	end
	assign o_level = i_oe ? i_drv : (i_ext_en ? i_ext_val : (i_pu ? 1'b1 : float_q));
endmodule : sp3c_board

`default_nettype wire

// ---- bench/sp3c_top_tb.sv ----
// Self-checking bench of the port-3 control block over its register port.
// Assumes the map header and the board model are compiled alongside.
`default_nettype none
`include "sp3c_map.svh"

module sp3c_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic       clk, rst, wr_stb, rd_stb, ext_en, ext_val, pin_lvl;
	logic [7:0] addr, wdata, rdata;
	logic       pin, oe, pu, sch, slew, osc, page;
	int         err_total, check_count;

	sp3c_top u_sp3c_top (.i_ref_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr_stb), .i_rd(rd_stb), .o_rdata(rdata), .i_pin(pin_lvl), .o_pin(pin),
		.o_pin_oe(oe), .o_weak_pu(pu), .o_schmitt(sch), .o_fast_slew(slew),
		.o_osc_in_en(osc), .o_page(page));
	sp3c_board u_sp3c_board (.i_ref_clk(clk), .i_drv(pin), .i_oe(oe), .i_pu(pu),
		.i_ext_en(ext_en), .i_ext_val(ext_val), .o_level(pin_lvl));

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr_stb <= 1'b1;
		addr   <= a;
		wdata  <= d;
		@(posedge clk);
		wr_stb <= 1'b0;
		#1;
	endtask : reg_write

	task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		rd_stb <= 1'b1;
		addr   <= a;
		@(posedge clk);
		rd_stb <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask : reg_read

	// Pin-side outputs packed: page, osc, slew, schmitt, pull-up, enable, drive
	task automatic stat(input logic [7:0] exp);
		chk({1'b0, page, osc, slew, sch, pu, oe, pin}, exp);
	endtask : stat

	task automatic results;
		$display("errors %0d checks %0d", err_total, check_count);
		if (err_total == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : results

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial begin
		repeat (2000) @(posedge clk);
		err_total++;
		results();
	end

	initial begin
		rst = 1'b1; wr_stb = 1'b0; rd_stb = 1'b0; addr = 8'h00; wdata = 8'h00;
		ext_en = 1'b1; ext_val = 1'b0; err_total = 0; check_count = 0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		#1;
		stat(8'h00);
		reg_read(`SP3C_ADDR_MODE_A_THR, 8'h01);
		reg_read(`SP3C_ADDR_MODE_B_SLEW, 8'h00);
		reg_read(`SP3C_ADDR_PIN_DATA, 8'h00);
		reg_write(`SP3C_ADDR_MODE_B_SLEW, 8'h01);
		reg_write(`SP3C_ADDR_MODE_A_THR, 8'h00);
		stat(8'h03);
		ext_en <= 1'b0;
		reg_read(`SP3C_ADDR_PIN_DATA, 8'h01);
		reg_write(`SP3C_ADDR_PAGE_CTRL, 8'h01);
		stat(8'h43);
		reg_read(`SP3C_ADDR_MODE_A_THR, 8'h00);
		reg_read(`SP3C_ADDR_MODE_B_SLEW, 8'h00);
		reg_write(`SP3C_ADDR_MODE_A_THR, 8'hFF);
		stat(8'h4B);
		reg_read(`SP3C_ADDR_MODE_A_THR, 8'h01);
		reg_write(`SP3C_ADDR_MODE_B_SLEW, 8'hFF);
		stat(8'h5B);
		reg_write(`SP3C_ADDR_MODE_A_THR, 8'h00);
		stat(8'h53);
		reg_read(`SP3C_ADDR_PAGE_CTRL, 8'h01);
		reg_write(`SP3C_ADDR_PAGE_CTRL, 8'h00);
		reg_read(`SP3C_ADDR_MODE_B_SLEW, 8'h01);
		for (int m = 0; m < 4; m++) begin
			for (int l = 0; l < 2; l++) begin
				logic [1:0] mv;
				logic       lv, e_oe, e_pin, e_pu;
				mv = m[1:0];
				lv = l[0];
				e_oe = (mv == 2'b01) | ((mv == 2'b00 || mv == 2'b11) & !lv);
				e_pin = (mv == 2'b01) & lv;
				e_pu = (mv == 2'b00) & lv;
				reg_write(`SP3C_ADDR_MODE_A_THR, {7'h00, mv[1]});
				reg_write(`SP3C_ADDR_MODE_B_SLEW, {7'h00, mv[0]});
				reg_write(`SP3C_ADDR_PIN_DATA, {7'h7F, lv});
				stat({4'h1, 1'b0, e_pu, e_oe, e_pin});
				if (e_oe | e_pu) begin
					reg_read(`SP3C_ADDR_PIN_DATA, {7'h00, e_pin | e_pu});
				end
			end
		end
		ext_en <= 1'b1;
		ext_val <= 1'b1;
		reg_write(`SP3C_ADDR_PAGE_CTRL, 8'h02);
		stat(8'h30);
		reg_write(`SP3C_ADDR_PIN_DATA, 8'h00);
		reg_read(`SP3C_ADDR_PIN_DATA, 8'h00);
		reg_read(`SP3C_ADDR_PAGE_CTRL, 8'h02);
		reg_read(8'h55, 8'h00);
		reg_write(`SP3C_ADDR_PAGE_CTRL, 8'h00);
		ext_en <= 1'b0;
		reg_write(`SP3C_ADDR_MODE_A_THR, 8'h00);
		reg_write(`SP3C_ADDR_MODE_B_SLEW, 8'h01);
		stat(8'h13);
		reg_write(`SP3C_ADDR_PIN_DATA, 8'h00);
		reg_write(`SP3C_ADDR_PAGE_CTRL, 8'h01);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		stat(8'h00);
		reg_write(`SP3C_ADDR_MODE_A_THR, 8'h00);
		stat(8'h04);
		results();
	end
endmodule : sp3c_top_tb

`default_nettype wire
